// file: inc/eswd_pkg.sv
// Package of timing constants and carrier types for the edge serviced watchdog.
package eswd_pkg;

  // ---------------------------------------------------------------------------
  // Clock and nominal durations
  // ---------------------------------------------------------------------------
  localparam longint CLK_HZ = 25000000; // Reference clock rate in hertz.
  localparam longint TIMEOUT_MS = 1600; // Nominal watchdog timeout in ms.
  localparam longint PULSE_MS = 140; // Least fault pulse length in ms.
  localparam longint MIN_SERVICE_NS = 50; // Narrowest service pulse in ns.
  // Cycle counts; the pulse is a least time, so it rounds up.
  localparam longint TIMEOUT_CYC = (TIMEOUT_MS * CLK_HZ) / 1000;
  localparam longint PULSE_CYC = (PULSE_MS * CLK_HZ + 999) / 1000;
  // A 50 ns pulse spans at least one 40 ns clock edge when synchronous.
  localparam longint SERVICE_CYC_RAW = (MIN_SERVICE_NS * CLK_HZ) / 1000000000;
  localparam longint SERVICE_CYC = (SERVICE_CYC_RAW < 1) ? 1 : SERVICE_CYC_RAW;
  // Width of the counters.
  localparam int CNT_W = 32;
  // Internal driver: low for 7/8, high for the final 1/8 of its period.
  localparam int DRV_HI_NUM = 7;
  localparam int DRV_DEN = 8;

  // ---------------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------------
  // Status bundle of the supervisor, as seen from outside.
  typedef struct packed {
    logic fault_active; // Fault output asserted: pulse period or lockout.
    logic self_serviced; // Internal driver selected as service source.
  } eswd_status_t;

endpackage : eswd_pkg

// file: verif/eswd_host_model.sv
// Processor side model that services or releases the watchdog service line.
`timescale 1ns/1ps
module eswd_host_model (
  input wire logic i_clk,
  output logic o_service_in,
  output logic o_service_float
);
  // Line starts driven low, which is the low-current resting level.
  initial begin
    o_service_in = 1'b0;
    o_service_float = 1'b0;
  end
  // A released line holds no level, so it flips each cycle to expose a stale read.
  always @(posedge i_clk) begin
    if (o_service_float) begin
      #1 o_service_in = ~o_service_in;
    end
  end
  // Set and clear the line at separate points, gap cycles apart.
  task toggle_gap(input int gap, input int num);
    repeat (num) begin
      repeat (gap) @(posedge i_clk);
      #1 o_service_in = ~o_service_in;
    end
  endtask : toggle_gap
  // One single-cycle low-high-low pulse after a wait.
  task narrow_pulse(input int gap);
    repeat (gap) @(posedge i_clk);
    #1 o_service_in = 1'b1;
    @(posedge i_clk);
    #1 o_service_in = 1'b0;
  endtask : narrow_pulse
  // Three-state or drive the line again.
  task set_float(input logic f);
    @(posedge i_clk);
    #1 o_service_float = f;
  endtask : set_float
endmodule : eswd_host_model

// file: verif/eswd_top_tb_top.sv
// Self-checking testbench for the edge serviced watchdog.
`timescale 1ns/1ps
module eswd_top_tb_top import eswd_pkg::*;;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  localparam int T = 100; // Shortened timeout count, keeps the run short.
  localparam int P = 20; // Shortened fault pulse count.
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic lockout = 1'b0;
  logic service_in;
  logic service_float;
  logic fault_n;
  eswd_status_t status;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int low_cnt = 0; // Cycles with the fault output not high.
  int n;
  int base;
  always #20 i_clk = ~i_clk;
  eswd_host_model i_host (.i_clk(i_clk), .o_service_in(service_in),
    .o_service_float(service_float));
  eswd_top #(.TIMEOUT_CNT(CNT_W'(T)), .PULSE_CNT(CNT_W'(P)), .DRIVER_CNT(CNT_W'(80))) i_dut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_service_in(service_in),
    .i_service_float(service_float), .i_supply_low_lockout(lockout),
    .o_fault_pulse_n(fault_n), .o_status(status));
  // Cycle counter with a ceiling; a hang counts as a mismatch.
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (fault_n !== 1'b1) low_cnt <= low_cnt + 1;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Sample two ns after the edge so registered outputs have settled.
  task step;
    @(posedge i_clk);
    #2;
  endtask : step
  task check_rng(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) begin
      errors++;
      $display("wrong value at %0t: got %0h expected %0h to %0h", $time, got, lo, hi);
    end
  endtask : check_rng
  task check_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check_bit
  // Count cycles while the fault output stays at one level, bounded.
  task measure(input logic lvl, output int cnt);
    cnt = 0;
    while (fault_n === lvl && cnt < 2000) begin
      cnt++;
      step();
    end
  endtask : measure
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // No service at all: timer expires, then a full fault pulse.
  task t_timeout;
    measure(1'b1, n);
    check_rng(n, T, T + 1);
    check_bit(status.fault_active, 1'b1);
    measure(1'b0, n);
    check_rng(n, P, P + 1);
  endtask : t_timeout
  // Edges during the pulse must not shorten it nor shift the next timeout.
  task t_refuse;
    measure(1'b1, n);
    fork
      i_host.toggle_gap(3, 4);
      measure(1'b0, n);
    join
    check_rng(n, P, P + 1);
    measure(1'b1, n);
    check_rng(n, T, T + 1);
    measure(1'b0, n);
  endtask : t_refuse
  // Slow toggles and narrow pulses keep the output high.
  task t_service;
    base = low_cnt;
    i_host.toggle_gap(60, 4);
    repeat (3) i_host.narrow_pulse(90);
    check_rng(low_cnt - base, 0, 0);
    measure(1'b1, n);
    check_rng(n, T - 1, T + 2);
    measure(1'b0, n);
  endtask : t_service
  // Released line: the internal driver services the timer.
  task t_float;
    base = low_cnt;
    i_host.set_float(1'b1);
    step();
    check_bit(status.self_serviced, 1'b1);
    repeat (400) step();
    check_rng(low_cnt - base, 0, 0);
    i_host.set_float(1'b0);
  endtask : t_float
  // Lockout holds the output low, then a full pulse after it ends.
  task t_lockout;
    @(posedge i_clk);
    #1 lockout = 1'b1;
    base = low_cnt;
    repeat (30) step();
    check_rng(low_cnt - base, 29, 30);
    lockout = 1'b0;
    measure(1'b0, n);
    check_rng(n, P, P + 2);
  endtask : t_lockout
  // Prints the counts and the verdict, then stops the run.
  task final_report;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  // Main sequence: reset for six cycles, then each scenario in turn.
  initial begin
    repeat (6) @(posedge i_clk);
    #1 i_rstn = 1'b1;
    #1;
    measure(1'b0, n);
    check_rng(n, P, P + 3);
    t_timeout();
    t_refuse();
    t_service();
    t_float();
    t_lockout();
    final_report();
  end
endmodule : eswd_top_tb_top

// file: verilog/eswd_int_driver.sv
// Internal service driver: a single period counter that makes a low-high-low pulse.
`timescale 1ns/1ps
module eswd_int_driver import eswd_pkg::*; #(
  parameter logic [CNT_W-1:0] PERIOD_CYC = CNT_W'(TIMEOUT_CYC) // Driver period.
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  output logic o_level
);

  // ---------------------------------------------------------------------------
  // Period counter
  // ---------------------------------------------------------------------------
  logic [CNT_W-1:0] cnt; // Position within the driver period.
  logic [CNT_W-1:0] next_cnt; // Next position.
  logic next_level; // Next driven level.
  // High threshold is 7/8 of the period; computed once, wide to avoid overflow.
  localparam logic [CNT_W-1:0] HI_AT =
    CNT_W'((64'(PERIOD_CYC) * DRV_HI_NUM) / DRV_DEN);

  // Next-state logic: count and choose the level for the next cycle.
  always_comb begin
    if (cnt >= PERIOD_CYC - CNT_W'(1)) begin
      next_cnt = '0;
    end else begin
      next_cnt = cnt + CNT_W'(1);
    end
    // Low for the first 7/8, high for the last 1/8.
    next_level = (next_cnt >= HI_AT);
  end

  // Register the counter and the level; level comes from a flip-flop.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      cnt <= '0;
      o_level <= 1'b0;
    end else begin
      cnt <= next_cnt;
      o_level <= next_level;
    end
  end

  // The level rises exactly at the 7/8 point of each period.
  chk_drv_rise_point: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $rose(o_level) |-> cnt == HI_AT)
    else $error("internal driver rose away from the 7/8 point");

endmodule : eswd_int_driver

// file: verilog/eswd_top.sv
// Edge serviced watchdog supervisor with fault pulse and lockout hold.
// Overview of operation
// - Timeout drives fault low at least 140ms.
// - Lockout holds fault low, then 140ms more.
// - Constant service level lets timer expire.
// - Either service edge clears the timer.
// - Service pulses of 50ns are recognised.
// - Timer held cleared while fault asserted.
// - Timer restarts from zero at release.
// - Floating input disables supervision by self-service.
// - Internal driver low 7/8, high 1/8.
// - Internal edges clear timer before timeout.
`timescale 1ns/1ps
module eswd_top import eswd_pkg::*; #(
  parameter logic [CNT_W-1:0] TIMEOUT_CNT = CNT_W'(TIMEOUT_CYC), // Timeout cycles.
  parameter logic [CNT_W-1:0] PULSE_CNT = CNT_W'(PULSE_CYC), // Fault pulse cycles.
  parameter logic [CNT_W-1:0] DRIVER_CNT = CNT_W'((TIMEOUT_CYC * 7) / 8) // Driver period.
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_service_in,
  input wire logic i_service_float,
  input wire logic i_supply_low_lockout,
  output logic o_fault_pulse_n,
  output eswd_status_t o_status
);

  // ---------------------------------------------------------------------------
  // Service source selection
  // ---------------------------------------------------------------------------
  logic drv_level; // Level made by the internal driver.
  logic svc_level; // Selected service level.
  logic svc_prev; // Service level one cycle ago.
  logic next_svc_prev; // Next stored level.
  logic svc_edge; // Either edge of the service level.

  // The driver period defaults to 7/8 of the timeout, so its high phase ends
  // near 1.4s and its edges always land before the timeout expires.
  eswd_int_driver #(
    .PERIOD_CYC(DRIVER_CNT)
  ) u_drv (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .o_level(drv_level)
  );

  // Choose the source and detect edges; the input is synchronous, so a
  // 50 ns pulse spans at least one sampling edge of the 40 ns clock.
  always_comb begin
    svc_level = i_service_float ? drv_level : i_service_in;
    next_svc_prev = svc_level;
    svc_edge = (svc_level != svc_prev);
  end

  // Register the previous service level.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      svc_prev <= 1'b0;
    end else begin
      svc_prev <= next_svc_prev;
    end
  end

  // ---------------------------------------------------------------------------
  // Timer and fault state machine
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ESWD_LOCK,
    ESWD_PULSE,
    ESWD_RUN
  } eswd_state_t;

  eswd_state_t state; // Current phase.
  eswd_state_t next_state; // Next phase.
  logic [CNT_W-1:0] timer; // Watchdog timer.
  logic [CNT_W-1:0] next_timer; // Next timer value.
  logic [CNT_W-1:0] pcnt; // Fault pulse length counter.
  logic [CNT_W-1:0] next_pcnt; // Next pulse count.
  logic next_fault_n; // Next fault output level.

  // Next-state logic. Lockout overrides everything; the hold after lockout
  // reuses the pulse phase, so both share one counted 140 ms interval.
  always_comb begin
    next_state = state;
    next_timer = timer;
    next_pcnt = pcnt;
    unique case (state)
      ESWD_LOCK: begin
        next_timer = '0;
        next_pcnt = '0;
        if (!i_supply_low_lockout) begin
          next_state = ESWD_PULSE;
        end
      end
      ESWD_PULSE: begin
        next_timer = '0;
        if (pcnt >= PULSE_CNT - CNT_W'(1)) begin
          next_state = ESWD_RUN;
          next_pcnt = '0;
        end else begin
          next_pcnt = pcnt + CNT_W'(1);
        end
      end
      ESWD_RUN: begin
        if (svc_edge) begin
          next_timer = '0;
        end else if (timer >= TIMEOUT_CNT - CNT_W'(1)) begin
          next_state = ESWD_PULSE;
          next_timer = '0;
        end else begin
          next_timer = timer + CNT_W'(1);
        end
      end
    endcase
    if (i_supply_low_lockout) begin
      next_state = ESWD_LOCK;
      next_timer = '0;
      next_pcnt = '0;
    end
    // Output is low in every phase except running.
    next_fault_n = (next_state == ESWD_RUN);
  end

  // Register the phase, counters and output. Reset acts as lockout.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state <= ESWD_LOCK;
      timer <= '0;
      pcnt <= '0;
      o_fault_pulse_n <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      pcnt <= next_pcnt;
      o_fault_pulse_n <= next_fault_n;
    end
  end

  // fault_active is decoded from registered state; self_serviced follows the float input directly.
  always_comb begin
    o_status.fault_active = (state != ESWD_RUN);
    o_status.self_serviced = i_service_float;
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  chk_lock_holds_low: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_supply_low_lockout |=> !o_fault_pulse_n)
    else $error("fault output released during lockout");

  chk_pulse_min_len: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $rose(o_fault_pulse_n) |-> $past(pcnt) == PULSE_CNT - CNT_W'(1))
    else $error("fault pulse released before its full length");

  chk_timer_cleared: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !o_fault_pulse_n |-> timer == '0)
    else $error("timer counting while fault asserted");

  chk_restart_zero: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $rose(o_fault_pulse_n) ##1 (o_fault_pulse_n && !svc_edge) |-> timer == CNT_W'(1))
    else $error("timer did not restart from zero");

  chk_edge_clears: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (state == ESWD_RUN && svc_edge && !i_supply_low_lockout) |=> timer == '0)
    else $error("service edge did not clear timer");

  chk_timeout_fault: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (state == ESWD_RUN && !svc_edge && timer == TIMEOUT_CNT - CNT_W'(1))
      |=> !o_fault_pulse_n)
    else $error("timeout did not start a fault pulse");

  chk_float_no_fault: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (state == ESWD_RUN && i_service_float && $past(i_service_float) && !i_supply_low_lockout)
      |=> state != ESWD_PULSE)
    else $error("fault pulse while self serviced");

  chk_fault_source: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_fault_pulse_n |-> state == ESWD_RUN)
    else $error("fault output high outside running phase");

endmodule : eswd_top
